// ===== verilog/dpch_top.sv
`timescale 1ns/1ps
`include "dpch_defs.svh"

// Behaviour
// R1: Temperature limit at parameter 110, range 10 to 80, default 80, saved.
// R2: Command -6 resets the whole drive like a supply cycle.
// R3: Command -5 loads defaults, saves them, then moves to mid-range.
// R4: Command -4 restores user-saved values, then moves to mid-range.
// R5: Command -3 loads defaults, erases network settings, saves to memory.
// R6: Command -2 restores user-saved values without saving.
// R7: Command -1 loads defaults without saving.
// R8: Command 1 saves parameters, accepted only while the drive stands still.
// R9: Command parameter 113 is signed 16-bit, not saved, seven valid codes.
// R10: During mid-range move steady control word ignored; a change aborts.
// R11: After mid-range move old run commands are not resumed.
// R12: Over-temperature set above limit, cleared 5 degrees below it.
// R13: Parameter access uses identifier, index and 32-bit value words.
// R14: Undefined codes or save while moving change nothing.
module dpch_top
(
    input  wire logic        ref_clk_i,
    input  wire logic        srst_i,
    input  wire logic        pd_valid_i,
    input  wire logic [15:0] param_identifier_word_i,
    input  wire logic [15:0] param_subindex_word_i,
    input  wire logic [31:0] param_value_field_i,
    input  wire logic [15:0] control_word_i,
    input  wire logic [15:0] temperature_i,
    input  wire logic        drive_moving_i,
    input  wire logic        mid_move_done_i,
    output logic [15:0]      param_identifier_word_o,
    output logic [15:0]      param_subindex_word_o,
    output logic [31:0]      param_value_field_o,
    output logic             resp_valid_o,
    output logic             over_temp_o,
    output logic [15:0]      temperature_limit_o,
    output logic [15:0]      control_word_o,
    output logic             drive_reset_o,
    output logic             load_defaults_o,
    output logic             restore_user_o,
    output logic             nvm_save_o,
    output logic             net_erase_o,
    output logic             mid_move_start_o,
    output logic             mid_move_abort_o,
    output logic             mid_move_active_o
);

    logic [63:0] last_req;
    logic [3:0]  req_code;
    logic [10:0] req_num;
    logic [15:0] cmd_code;
    logic        is_new;
    logic        wr_limit_ok;
    logic        cmd_known;
    logic        cmd_ok;
    logic        take_cmd;
    logic        take_limit;
    logic [15:0] saved_limit;
    logic [16:0] temp_s;
    logic [16:0] lim_s;
    logic [16:0] clear_s;

    // Request decode; a request repeated in every cycle acts only once
    assign req_code = param_identifier_word_i[`DPCH_IDW_CODE_MSB:
                                              `DPCH_IDW_CODE_LSB];
    assign req_num  = param_identifier_word_i[`DPCH_IDW_NUM_MSB:
                                              `DPCH_IDW_NUM_LSB];
    assign cmd_code = param_value_field_i[15:0];
    assign is_new   = pd_valid_i && req_code != `DPCH_REQ_NONE
                   && {param_identifier_word_i, param_subindex_word_i,
                       param_value_field_i} != last_req; // R13

    // Limit writes outside the legal band are refused
    assign wr_limit_ok = param_value_field_i[31:16] == 16'h0000
                      && cmd_code >= `DPCH_TEMP_LIMIT_MIN
                      && cmd_code <= `DPCH_TEMP_LIMIT_MAX; // R1

    assign cmd_known = param_value_field_i[31:16]
                       == {16{param_value_field_i[15]}}
                    && (cmd_code == `DPCH_CMD_RESET
                    ||  cmd_code == `DPCH_CMD_DEF_SAVE_MID
                    ||  cmd_code == `DPCH_CMD_USER_MID
                    ||  cmd_code == `DPCH_CMD_DEF_NET
                    ||  cmd_code == `DPCH_CMD_USER
                    ||  cmd_code == `DPCH_CMD_DEF
                    ||  cmd_code == `DPCH_CMD_SAVE); // R9
    // Saving during a run would capture a moving set point
    assign cmd_ok = cmd_known
                 && !(cmd_code == `DPCH_CMD_SAVE && drive_moving_i); // R8 R14

    assign take_cmd   = is_new && req_code == `DPCH_REQ_WRITE
                     && req_num == `DPCH_PAR_COMMAND && cmd_ok;
    assign take_limit = is_new && req_code == `DPCH_REQ_WRITE
                     && req_num == `DPCH_PAR_TEMP_LIMIT && wr_limit_ok;

    // Last request seen, for change detection
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            last_req <= 64'h0000_0000_0000_0000;
        else if (is_new)
            last_req <= {param_identifier_word_i, param_subindex_word_i,
                         param_value_field_i};
    end

    // Live and user-saved temperature limit
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            temperature_limit_o <= `DPCH_TEMP_LIMIT_RST;
            saved_limit         <= `DPCH_TEMP_LIMIT_RST;
        end
        else
        begin
            if (load_defaults_o)
                temperature_limit_o <= `DPCH_TEMP_LIMIT_RST; // R1 R3 R7
            else if (restore_user_o)
                temperature_limit_o <= saved_limit; // R4 R6
            else if (take_limit)
                temperature_limit_o <= cmd_code; // R1
            if (nvm_save_o && load_defaults_o)
                saved_limit <= `DPCH_TEMP_LIMIT_RST; // R3 R5
            else if (nvm_save_o)
                saved_limit <= temperature_limit_o; // R8
        end
    end

    // Over-temperature with hysteresis; signed compare on one extra bit
    assign temp_s  = {temperature_i[15], temperature_i};
    assign lim_s   = {1'b0, temperature_limit_o};
    assign clear_s = lim_s - {1'b0, `DPCH_TEMP_HYST};

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            over_temp_o <= 1'b0;
        else if ($signed(temp_s) > $signed(lim_s))
            over_temp_o <= 1'b1; // R12
        else if ($signed(temp_s) <= $signed(clear_s))
            over_temp_o <= 1'b0; // R12
    end

    // Answer in the same three-word layout, one cycle after the request
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            resp_valid_o            <= 1'b0;
            param_identifier_word_o <= 16'h0000;
            param_subindex_word_o   <= 16'h0000;
            param_value_field_o     <= 32'h0000_0000;
        end
        else
        begin
            resp_valid_o <= is_new; // R13
            if (is_new)
            begin
                param_subindex_word_o   <= param_subindex_word_i;
                param_identifier_word_o <= {`DPCH_RSP_ERROR, 1'b0, req_num};
                param_value_field_o     <= 32'h0000_0000;
                if (req_code == `DPCH_REQ_READ
                    && req_num == `DPCH_PAR_TEMP_LIMIT)
                begin
                    param_identifier_word_o <= {`DPCH_RSP_VALUE, 1'b0,
                                                req_num};
                    param_value_field_o     <= {16'h0000,
                                                temperature_limit_o};
                end
                else if (req_code == `DPCH_REQ_READ
                         && req_num == `DPCH_PAR_COMMAND)
                    param_identifier_word_o <= {`DPCH_RSP_VALUE, 1'b0,
                                                req_num}; // R9
                else if (take_limit || take_cmd)
                begin
                    param_identifier_word_o <= {`DPCH_RSP_VALUE, 1'b0,
                                                req_num};
                    param_value_field_o     <= param_value_field_i;
                end
            end
        end
    end

    dpch_cmd_exec u_exec
    (
        .ref_clk_i         (ref_clk_i),
        .srst_i            (srst_i),
        .cmd_valid_i       (take_cmd),
        .cmd_code_i        (cmd_code),
        .control_word_i    (control_word_i),
        .mid_move_done_i   (mid_move_done_i),
        .drive_reset_o     (drive_reset_o),
        .load_defaults_o   (load_defaults_o),
        .restore_user_o    (restore_user_o),
        .nvm_save_o        (nvm_save_o),
        .net_erase_o       (net_erase_o),
        .mid_move_start_o  (mid_move_start_o),
        .mid_move_abort_o  (mid_move_abort_o),
        .mid_move_active_o (mid_move_active_o),
        .control_word_o    (control_word_o)
    );

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);

    sequence s_cmd(logic [15:0] c);
        take_cmd && cmd_code == c;
    endsequence

    property p_limit_band;
        temperature_limit_o >= `DPCH_TEMP_LIMIT_MIN
        && temperature_limit_o <= `DPCH_TEMP_LIMIT_MAX;
    endproperty
    a_limit_band: assert property (p_limit_band) // R1
        else $error("Temperature limit left its band");

    property p_reset_cmd;
        s_cmd(`DPCH_CMD_RESET) |=> drive_reset_o && !load_defaults_o;
    endproperty
    a_reset_cmd: assert property (p_reset_cmd) // R2
        else $error("Reset command did not reset the drive");

    property p_def_save_mid;
        s_cmd(`DPCH_CMD_DEF_SAVE_MID) |=> load_defaults_o && nvm_save_o
            && mid_move_start_o && !net_erase_o
            ##1 temperature_limit_o == `DPCH_TEMP_LIMIT_RST
            && mid_move_active_o;
    endproperty
    a_def_save_mid: assert property (p_def_save_mid) // R3
        else $error("Default-save-move sequence wrong");

    property p_user_mid;
        s_cmd(`DPCH_CMD_USER_MID) |=> restore_user_o && mid_move_start_o
            && !nvm_save_o ##1 temperature_limit_o == $past(saved_limit);
    endproperty
    a_user_mid: assert property (p_user_mid) // R4
        else $error("Restore-move sequence wrong");

    property p_def_net;
        s_cmd(`DPCH_CMD_DEF_NET) |=> load_defaults_o && net_erase_o
            && nvm_save_o && !mid_move_start_o;
    endproperty
    a_def_net: assert property (p_def_net) // R5
        else $error("Network erase command wrong");

    property p_user;
        s_cmd(`DPCH_CMD_USER) |=> restore_user_o && !nvm_save_o
            && !mid_move_start_o;
    endproperty
    a_user: assert property (p_user) // R6
        else $error("Restore command wrong");

    property p_def;
        s_cmd(`DPCH_CMD_DEF) |=> load_defaults_o && !nvm_save_o
            && !net_erase_o && !mid_move_start_o;
    endproperty
    a_def: assert property (p_def) // R7
        else $error("Defaults command wrong");

    property p_save_moving;
        is_new && req_code == `DPCH_REQ_WRITE
        && req_num == `DPCH_PAR_COMMAND
        && cmd_code == `DPCH_CMD_SAVE && drive_moving_i
            |=> !nvm_save_o && resp_valid_o
            && param_identifier_word_o[15:12] == `DPCH_RSP_ERROR;
    endproperty
    a_save_moving: assert property (p_save_moving) // R8 R14
        else $error("Save accepted while moving");

    property p_bad_code;
        is_new && req_num == `DPCH_PAR_COMMAND && !cmd_known
            |=> !drive_reset_o && !load_defaults_o && !restore_user_o
            && !nvm_save_o && $stable(temperature_limit_o);
    endproperty
    a_bad_code: assert property (p_bad_code) // R14
        else $error("Undefined command had an effect");

    property p_over_temp;
        $signed(temp_s) > $signed(lim_s) |=> over_temp_o;
    endproperty
    a_over_temp: assert property (p_over_temp) // R12
        else $error("Over-temperature flag not set");

    property p_temp_hold;
        over_temp_o && $signed(temp_s) > $signed(clear_s) |=> over_temp_o;
    endproperty
    a_temp_hold: assert property (p_temp_hold) // R12
        else $error("Over-temperature cleared inside hysteresis");

    property p_answer;
        is_new |=> resp_valid_o
            && param_subindex_word_o == $past(param_subindex_word_i);
    endproperty
    a_answer: assert property (p_answer) // R13
        else $error("Parameter request not answered");

endmodule

// ===== verilog/dpch_defs.svh
`ifndef DPCH_DEFS_SVH
`define DPCH_DEFS_SVH

// Parameter numbers carried in the identifier word
`define DPCH_PAR_TEMP_LIMIT   11'h06E
`define DPCH_PAR_COMMAND      11'h071

// Identifier word layout: request or answer code, parameter number
`define DPCH_IDW_CODE_MSB     15
`define DPCH_IDW_CODE_LSB     12
`define DPCH_IDW_NUM_MSB      10
`define DPCH_IDW_NUM_LSB      0

// Request and answer codes
`define DPCH_REQ_NONE         4'h0
`define DPCH_REQ_READ         4'h1
`define DPCH_REQ_WRITE        4'h2
`define DPCH_RSP_VALUE        4'h1
`define DPCH_RSP_ERROR        4'h7

// Temperature limit in degrees Celsius
`define DPCH_TEMP_LIMIT_MIN   16'h000A
`define DPCH_TEMP_LIMIT_MAX   16'h0050
`define DPCH_TEMP_LIMIT_RST   16'h0050
`define DPCH_TEMP_HYST        16'h0005

// Command codes, signed 16-bit
`define DPCH_CMD_RESET        16'hFFFA
`define DPCH_CMD_DEF_SAVE_MID 16'hFFFB
`define DPCH_CMD_USER_MID     16'hFFFC
`define DPCH_CMD_DEF_NET      16'hFFFD
`define DPCH_CMD_USER         16'hFFFE
`define DPCH_CMD_DEF          16'hFFFF
`define DPCH_CMD_SAVE         16'h0001

`endif

// ===== verilog/dpch_pkg.sv
package dpch_pkg;

    // Mid-range move sequencer
    typedef enum logic [0:0]
    {
        DPCH_IDLE,
        DPCH_MOVING
    } dpch_mid_state_type;

endpackage

// ===== verilog/dpch_cmd_exec.sv
`timescale 1ns/1ps
`include "dpch_defs.svh"

module dpch_cmd_exec
(
    input  wire logic        ref_clk_i,
    input  wire logic        srst_i,
    input  wire logic        cmd_valid_i,
    input  wire logic [15:0] cmd_code_i,
    input  wire logic [15:0] control_word_i,
    input  wire logic        mid_move_done_i,
    output logic             drive_reset_o,
    output logic             load_defaults_o,
    output logic             restore_user_o,
    output logic             nvm_save_o,
    output logic             net_erase_o,
    output logic             mid_move_start_o,
    output logic             mid_move_abort_o,
    output logic             mid_move_active_o,
    output logic [15:0]      control_word_o
);

    dpch_pkg::dpch_mid_state_type state;
    logic [15:0]                  held_cw;
    logic                         hold;
    logic                         starts;
    logic                         cw_changed;

    assign starts = cmd_valid_i
                 && (cmd_code_i == `DPCH_CMD_DEF_SAVE_MID
                 ||  cmd_code_i == `DPCH_CMD_USER_MID);
    assign cw_changed = control_word_i != held_cw;
    assign mid_move_active_o = state == dpch_pkg::DPCH_MOVING;

    // One-cycle action strobes decoded from an accepted command
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            drive_reset_o    <= 1'b0;
            load_defaults_o  <= 1'b0;
            restore_user_o   <= 1'b0;
            nvm_save_o       <= 1'b0;
            net_erase_o      <= 1'b0;
            mid_move_start_o <= 1'b0;
        end
        else
        begin
            drive_reset_o    <= cmd_valid_i
                             && cmd_code_i == `DPCH_CMD_RESET; // R2
            load_defaults_o  <= cmd_valid_i
                             && (cmd_code_i == `DPCH_CMD_DEF_SAVE_MID
                             ||  cmd_code_i == `DPCH_CMD_DEF_NET
                             ||  cmd_code_i == `DPCH_CMD_DEF); // R3 R5 R7
            restore_user_o   <= cmd_valid_i
                             && (cmd_code_i == `DPCH_CMD_USER_MID
                             ||  cmd_code_i == `DPCH_CMD_USER); // R4 R6
            nvm_save_o       <= cmd_valid_i
                             && (cmd_code_i == `DPCH_CMD_DEF_SAVE_MID
                             ||  cmd_code_i == `DPCH_CMD_DEF_NET
                             ||  cmd_code_i == `DPCH_CMD_SAVE); // R8
            net_erase_o      <= cmd_valid_i
                             && cmd_code_i == `DPCH_CMD_DEF_NET; // R5
            mid_move_start_o <= starts; // R3 R4
        end
    end

    // Mid-range move: a steady control word is ignored, a change aborts
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            state            <= dpch_pkg::DPCH_IDLE;
            held_cw          <= 16'h0000;
            hold             <= 1'b0;
            mid_move_abort_o <= 1'b0;
        end
        else
        begin
            mid_move_abort_o <= 1'b0;
            if (starts)
            begin
                state   <= dpch_pkg::DPCH_MOVING;
                held_cw <= control_word_i;
                hold    <= 1'b0;
            end
            else
            begin
                case (state)
                    dpch_pkg::DPCH_MOVING:
                    begin
                        if (cw_changed)
                        begin
                            state            <= dpch_pkg::DPCH_IDLE;
                            mid_move_abort_o <= 1'b1; // R10
                        end
                        else if (mid_move_done_i)
                        begin
                            state <= dpch_pkg::DPCH_IDLE;
                            hold  <= 1'b1; // R11
                        end
                    end
                    dpch_pkg::DPCH_IDLE:
                    begin
                        if (hold && cw_changed)
                            hold <= 1'b0;
                    end
                    default:
                        state <= dpch_pkg::DPCH_IDLE;
                endcase
            end
        end
    end

    // Old run commands stay blocked until the master writes a new word
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            control_word_o <= 16'h0000;
        else if (starts || mid_move_active_o || (hold && !cw_changed))
            control_word_o <= 16'h0000; // R10 R11
        else
            control_word_o <= control_word_i;
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);

    sequence s_steady_move;
        mid_move_active_o && !cw_changed;
    endsequence

    property p_abort_on_change;
        mid_move_active_o && !starts && cw_changed
            |=> mid_move_abort_o && !mid_move_active_o;
    endproperty
    a_abort_on_change: assert property (p_abort_on_change) // R10
        else $error("Control word change did not abort the move");

    property p_ignore_steady;
        s_steady_move ##1 s_steady_move |-> control_word_o == 16'h0000;
    endproperty
    a_ignore_steady: assert property (p_ignore_steady) // R10
        else $error("Control word passed during mid-range move");

    property p_no_resume;
        mid_move_active_o && !starts && !cw_changed && mid_move_done_i
            ##1 !cw_changed [*2] |-> control_word_o == 16'h0000;
    endproperty
    a_no_resume: assert property (p_no_resume) // R11
        else $error("Old run command resumed after mid-range move");

endmodule

// ===== test/dpch_master_model.sv
`timescale 1ns/1ps

// Fieldbus master: presents one parameter request per call of send
module dpch_master_model
(
    input  wire logic        ref_clk_i,
    output logic             pd_valid_o,
    output logic [15:0]      param_identifier_word_o,
    output logic [15:0]      param_subindex_word_o,
    output logic [31:0]      param_value_field_o
);
    // Idle channel carries no request code, so nothing can be taken
    initial
    begin
        pd_valid_o              = 1'b0;
        param_identifier_word_o = 16'h0000;
        param_subindex_word_o   = 16'h0000;
        param_value_field_o     = 32'h0000_0000;
    end

    // Index counts up, so a repeated command still forms a new triple
    task automatic send(input logic [15:0] id_word,
                        input logic [31:0] value);
        @(negedge ref_clk_i);
        pd_valid_o              = 1'b1;
        param_identifier_word_o = id_word;
        param_subindex_word_o   = param_subindex_word_o + 16'h0001;
        param_value_field_o     = value;
        @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        pd_valid_o              = 1'b0;
        param_identifier_word_o = ~id_word; // Stale words change once invalid
        param_value_field_o     = ~value;
    endtask
endmodule

// ===== test/dpch_top_tb.sv
`timescale 1ns/1ps
`include "dpch_defs.svh"

module dpch_top_tb;
    logic        ref_clk_i, srst_i, pd_valid_i, drive_moving_i;
    logic        mid_move_done_i, resp_valid_o, over_temp_o;
    logic        drive_reset_o, load_defaults_o, restore_user_o;
    logic        nvm_save_o, net_erase_o, mid_move_start_o;
    logic        mid_move_abort_o, mid_move_active_o, seen;
    logic [15:0] param_identifier_word_i, param_subindex_word_i;
    logic [15:0] param_identifier_word_o, param_subindex_word_o;
    logic [15:0] control_word_i, temperature_i, temperature_limit_o;
    logic [15:0] control_word_o, lim, lim2;
    logic [31:0] param_value_field_i, param_value_field_o, seed, v;
    logic [5:0]  pulses;
    int          num_errors = 0;
    int          compares = 0;

    assign pulses = {drive_reset_o, load_defaults_o, restore_user_o,
                     nvm_save_o, net_erase_o, mid_move_start_o};

    dpch_master_model dpch_master_model_i
    (
        .ref_clk_i,
        .pd_valid_o              (pd_valid_i),
        .param_identifier_word_o (param_identifier_word_i),
        .param_subindex_word_o   (param_subindex_word_i),
        .param_value_field_o     (param_value_field_i)
    );

    dpch_top dpch_top_i
    (
        .ref_clk_i, .srst_i, .pd_valid_i, .param_identifier_word_i,
        .param_subindex_word_i, .param_value_field_i, .control_word_i,
        .temperature_i, .drive_moving_i, .mid_move_done_i,
        .param_identifier_word_o, .param_subindex_word_o,
        .param_value_field_o, .resp_valid_o, .over_temp_o,
        .temperature_limit_o, .control_word_o, .drive_reset_o,
        .load_defaults_o, .restore_user_o, .nvm_save_o, .net_erase_o,
        .mid_move_start_o, .mid_move_abort_o, .mid_move_active_o
    );

    // 40 MHz clock
    initial
    begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    // Pulses expected for a command code; save is refused while moving
    function automatic logic [5:0] exp_pulses(input logic [15:0] c,
                                              input logic mv);
        case (c)
            `DPCH_CMD_RESET:        return 6'h20;
            `DPCH_CMD_DEF_SAVE_MID: return 6'h15;
            `DPCH_CMD_USER_MID:     return 6'h09;
            `DPCH_CMD_DEF_NET:      return 6'h16;
            `DPCH_CMD_USER:         return 6'h08;
            `DPCH_CMD_DEF:          return 6'h10;
            `DPCH_CMD_SAVE:         return mv ? 6'h00 : 6'h04;
            default:                return 6'h00;
        endcase
    endfunction

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string what, input logic [31:0] got,
                         input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Answer is sampled at the falling edge after the taking edge, while
    // the one-cycle answer strobe and the command pulses still stand
    task automatic req(input logic [15:0] id_word, input logic [31:0] value,
                       input logic [3:0] code, output logic [31:0] val);
        dpch_master_model_i.send(id_word, value);
        check("answer strobe", resp_valid_o, 32'h0000_0001);
        check("answer id", param_identifier_word_o,
              {code, 1'b0, id_word[10:0]});
        check("answer index", param_subindex_word_o,
              param_subindex_word_i);
        val = param_value_field_o;
    endtask

    task automatic cmd(input logic [15:0] c);
        logic [5:0]  e;
        logic [31:0] w;
        e = exp_pulses(c, drive_moving_i);
        w = {{16{c[15]}}, c};
        req({`DPCH_REQ_WRITE, 1'b0, `DPCH_PAR_COMMAND}, w,
            (e == 6'h00) ? `DPCH_RSP_ERROR : `DPCH_RSP_VALUE, v);
        check("command pulses", pulses, e);
        check("command echo", v, (e == 6'h00) ? 32'h0 : w);
    endtask

    task automatic wr_limit(input logic [31:0] w, input logic ok);
        req({`DPCH_REQ_WRITE, 1'b0, `DPCH_PAR_TEMP_LIMIT}, w,
            ok ? `DPCH_RSP_VALUE : `DPCH_RSP_ERROR, v);
    endtask

    task automatic rd_limit(input logic [15:0] exp);
        req({`DPCH_REQ_READ, 1'b0, `DPCH_PAR_TEMP_LIMIT}, 32'h0,
            `DPCH_RSP_VALUE, v);
        check("limit read", v, {16'h0000, exp});
    endtask

    // Lets n edges land, then samples
    task automatic wait_n(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    // Random in-range limit drawn from the bench LFSR
    task automatic draw(output logic [15:0] l);
        seed = lfsr(seed);
        l    = `DPCH_TEMP_LIMIT_MIN + (seed[15:0] % 16'h0047);
    endtask

    initial
    begin
        srst_i          = 1'b1;
        control_word_i  = 16'h0014;
        temperature_i   = 16'h0000;
        drive_moving_i  = 1'b0;
        mid_move_done_i = 1'b0;
        seed            = 32'h7970;
        repeat (16) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        srst_i = 1'b0;
        check("limit reset", temperature_limit_o, 16'h0050);
        rd_limit(`DPCH_TEMP_LIMIT_RST);
        // Command parameter reads back zero; unknown parameters are refused
        req({`DPCH_REQ_READ, 1'b0, `DPCH_PAR_COMMAND}, 32'h0000_0000,
            `DPCH_RSP_VALUE, v);
        check("command read", v, 32'h0000_0000);
        req({`DPCH_REQ_READ, 1'b0, 11'h06F}, 32'h0000_0000,
            `DPCH_RSP_ERROR, v);
        check("other read", v, 32'h0000_0000);
        // Range edges, upper half of value set, then a random limit
        wr_limit(32'h0000_0009, 1'b0);
        wr_limit(32'h0000_0051, 1'b0);
        wr_limit(32'h0001_0032, 1'b0);
        wr_limit(32'h0000_000A, 1'b1);
        rd_limit(16'h000A);
        draw(lim);
        wr_limit({16'h0000, lim}, 1'b1);
        cmd(`DPCH_CMD_SAVE);
        draw(lim2);
        wr_limit({16'h0000, lim2}, 1'b1);
        cmd(`DPCH_CMD_USER);
        rd_limit(lim);
        cmd(`DPCH_CMD_DEF);
        rd_limit(16'h0050);
        // Save while moving and undefined codes must change nothing
        @(negedge ref_clk_i);
        drive_moving_i = 1'b1;
        cmd(`DPCH_CMD_SAVE);
        drive_moving_i = 1'b0;
        cmd(16'h0005);
        cmd(16'hFFF9);
        cmd(`DPCH_CMD_DEF_NET);
        rd_limit(16'h0050);
        cmd(`DPCH_CMD_RESET);
        // Over-temperature with hysteresis of five degrees
        wr_limit({16'h0000, lim}, 1'b1);
        temperature_i = lim;
        wait_n(3);
        check("no over temp", over_temp_o, 32'h0);
        @(negedge ref_clk_i);
        temperature_i = lim + 16'h0001;
        wait_n(2);
        check("over temp set", over_temp_o, 32'h1);
        @(negedge ref_clk_i);
        temperature_i = lim - 16'h0004;
        wait_n(2);
        check("over temp held", over_temp_o, 32'h1);
        @(negedge ref_clk_i);
        temperature_i = lim - `DPCH_TEMP_HYST;
        wait_n(2);
        check("over temp clear", over_temp_o, 32'h0);
        // Mid-range move finishes; the old run word stays blocked
        cmd(`DPCH_CMD_DEF_SAVE_MID);
        check("move active", mid_move_active_o, 32'h1);
        check("word blocked", control_word_o, 32'h0);
        @(negedge ref_clk_i);
        mid_move_done_i = 1'b1;
        wait_n(3);
        check("move ended", mid_move_active_o, 32'h0);
        check("old word held", control_word_o, 32'h0);
        @(negedge ref_clk_i);
        mid_move_done_i = 1'b0;
        control_word_i = 16'h0015;
        wait_n(2);
        check("new word", control_word_o, 32'h0015);
        // Steady word is ignored, a changed word aborts the move
        cmd(`DPCH_CMD_USER_MID);
        wait_n(4);
        check("move kept", mid_move_active_o, 32'h1);
        @(negedge ref_clk_i);
        control_word_i = 16'h0016;
        seen = 1'b0;
        repeat (3)
        begin
            wait_n(1);
            seen = seen | mid_move_abort_o;
        end
        check("abort pulse", seen, 32'h1);
        check("aborted", mid_move_active_o, 32'h0);
        conclude();
    end

    // Whole run is about a hundred cycles; this is far beyond it
    initial
    begin
        #125000;
        num_errors++;
        conclude();
    end

    task automatic conclude();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
endmodule
